// >>> inc/rcs_pkg.sv
// constants and types for the repeater configuration selector
package rcs_pkg;

  // ****************************************************************
  // four-level pin codes
  // ****************************************************************
  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_R = 2'h1;
  localparam logic [1:0] LVL_F = 2'h2;
  localparam logic [1:0] LVL_1 = 2'h3;
  localparam int NUM_STRAPS = 10;
  localparam int CMP_W = 3;

  // ****************************************************************
  // configuration source state
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_PIN = 2'b00,
    ST_LOAD = 2'b01,
    ST_SLAVE = 2'b10,
    ST_STALL = 2'b11
  } rcs_state_t;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_BOOST_A = 8'h01;
  localparam logic [7:0] IDX_BOOST_B = 8'h02;
  localparam logic [7:0] IDX_EMSW_A = 8'h03;
  localparam logic [7:0] IDX_EMSW_B = 8'h04;
  localparam logic [7:0] IDX_OVERRIDE = 8'h05;
  localparam logic [7:0] IDX_REG_EN = 8'h06;
  localparam logic [7:0] IDX_THRESH = 8'h07;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int REG_EN_BIT = 3;
  localparam int EMSW_EMPH_LSB = 0;
  localparam int EMSW_SWING_LSB = 3;
  localparam int OVR_TXOFF_EN = 0;
  localparam int OVR_TXOFF_VAL = 1;
  localparam int OVR_OPMODE_EN = 2;
  localparam int OVR_OPMODE_LSB = 3;
  localparam int OVR_THR_EN = 5;
  localparam int THR_A_LSB = 2;
  localparam int THR_B_LSB = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SD_LSB = 2;
  localparam int STAT_ADDR_LSB = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_BOOST = 8'h00;
  localparam logic [7:0] RST_EMSW = 8'h18;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_REG_EN = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h00;

  // ****************************************************************
  // slave address and timing
  // ****************************************************************
  localparam logic [7:0] ADDR_BYTE_BASE = 8'hb0;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DEB_TIME_NS = 1000;
  localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> design/rcs_sync.sv
// three-stage synchroniser with stability debounce
`timescale 1ns/1ps
module rcs_sync #(
  parameter int WIDTH = 1,
  parameter int DEB_CYCLES = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw and settled values
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  localparam int CNT_W = (DEB_CYCLES > 1) ? $clog2(DEB_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEB_CYCLES - 1);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [CNT_W-1:0] cnt;

  // ****************************************************************
  // synchroniser chain
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ****************************************************************
  // accept once stages two and three agree long enough
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt <= '0;
      q_out <= '0;
    end
    else if (s2 == s3 && s3 != q_out)
    begin
      if (cnt == CNT_LAST)
      begin
        q_out <= s3;
        cnt <= '0;
      end
      else
      begin
        cnt <= cnt + 1'b1;
      end
    end
    else
    begin
      cnt <= '0;
    end
  end

endmodule

// >>> design/rcs_top.sv
// repeater configuration source selection, pin decode and register file
// Contract
// - mode strap picks pin, slave or load
// - detector hysteresis gates each channel output
// - comparator thresholds resolve four pin levels
// - pin mode: each side own boost and emphasis pins
// - threshold pin levels map to codes
// - slave mode: settings come from registers
// - setting writes blocked until enable bit
// - setting pins become four address straps
// - control pins rule until override set
// - overridden pin ignored until pin mode
// - transmit off leaves registers unchanged
// - master mode loads own eeprom section
// - successful load enters slave, releases bus
// - failed load stalls, bus stays silent
// - pins reach only sixteen boost codes
// - boost codes for high pin 0, R
// - boost codes for high pin F, 1
// - pin mode: swing and emphasis paired
// - emphasis pin levels map to codes
// - swing pin levels map to codes
// - slave address is base plus straps
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module rcs_top
  import rcs_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // ahb-lite register slave
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // four-level straps as comparator triples above 0.2, 0.5, 0.8
  input wire logic [2:0] CONFIG_SOURCE_STRAP,
  input wire logic [2:0] DETECT_LEVEL_STRAP,
  input wire logic [2:0] SIDE_A_BOOST_HI,
  input wire logic [2:0] SIDE_A_BOOST_LO,
  input wire logic [2:0] SIDE_B_BOOST_HI,
  input wire logic [2:0] SIDE_B_BOOST_LO,
  input wire logic [2:0] EMPH_STRAP_A,
  input wire logic [2:0] EMPH_STRAP_B,
  input wire logic [2:0] SWING_SELECT_STRAP,
  input wire logic [2:0] OPMODE_STRAP,
  // two-level pins and detector comparators
  input wire logic TRANSMIT_OFF_PIN,
  input wire logic [1:0] SD_ABOVE_ASSERT,
  input wire logic [1:0] SD_BELOW_DEASSERT,
  // eeprom load engine
  input wire logic LD_WR,
  input wire logic [7:0] LD_IDX,
  input wire logic [7:0] LD_DATA,
  input wire logic LD_OK,
  input wire logic LD_FAIL,
  output logic LOAD_REQ,
  output logic [6:0] LOAD_SECTION,
  output logic SLAVE_EN,
  // settings to the datapath
  output logic [7:0] BOOST_A,
  output logic [7:0] BOOST_B,
  output logic [2:0] EMPH_A,
  output logic [2:0] EMPH_B,
  output logic [2:0] SWING_A,
  output logic [2:0] SWING_B,
  output logic [1:0] THRESH_A,
  output logic [1:0] THRESH_B,
  output logic [1:0] OPMODE,
  output logic TX_OFF,
  output logic [1:0] OUT_EN,
  output logic [6:0] SLAVE_ADDR,
  output logic [1:0] CFG_STATE
);

  // ****************************************************************
  // level and code functions
  // ****************************************************************
  function automatic logic [1:0] resolve(input logic [2:0] cmp);
    logic [1:0] lvl;
    lvl = LVL_0;
    if (cmp[2])
      lvl = LVL_1;
    else if (cmp[1])
      lvl = LVL_F;
    else if (cmp[0])
      lvl = LVL_R;
    return lvl;
  endfunction

  function automatic logic [7:0] boost_map(input logic [1:0] hi, input logic [1:0] lo);
    logic [7:0] c;
    c = 8'h00;
    unique case ({hi, lo})
      {LVL_0, LVL_0}: c = 8'h00;
      {LVL_0, LVL_R}: c = 8'h01;
      {LVL_0, LVL_F}: c = 8'h02;
      {LVL_0, LVL_1}: c = 8'h03;
      {LVL_R, LVL_0}: c = 8'h07;
      {LVL_R, LVL_R}: c = 8'h15;
      {LVL_R, LVL_F}: c = 8'h0b;
      {LVL_R, LVL_1}: c = 8'h0f;
      {LVL_F, LVL_0}: c = 8'h55;
      {LVL_F, LVL_R}: c = 8'h1f;
      {LVL_F, LVL_F}: c = 8'h2f;
      {LVL_F, LVL_1}: c = 8'h3f;
      {LVL_1, LVL_0}: c = 8'haa;
      {LVL_1, LVL_R}: c = 8'h7f;
      {LVL_1, LVL_F}: c = 8'hbf;
      {LVL_1, LVL_1}: c = 8'hff;
    endcase
    return c;
  endfunction

  // returns {swing, emphasis} as one fixed pair
  function automatic logic [5:0] emsw_map(input logic [1:0] sw, input logic [1:0] em);
    logic [2:0] e;
    logic [2:0] s;
    e = 3'h0;
    s = 3'h0;
    if (sw == LVL_1)
    begin
      unique case (em)
        LVL_0: e = 3'h0;
        LVL_F: e = 3'h1;
        LVL_R: e = 3'h1;
        LVL_1: e = 3'h2;
      endcase
      s = (em == LVL_0 || em == LVL_F) ? 3'h4 : 3'h6;
    end
    else
    begin
      unique case (em)
        LVL_0: e = 3'h0;
        LVL_F: e = 3'h2;
        LVL_R: e = 3'h3;
        LVL_1: e = 3'h5;
      endcase
      unique case (sw)
        LVL_0: s = 3'h0;
        LVL_F: s = 3'h3;
        LVL_R: s = 3'h5;
        LVL_1: s = 3'h0;
      endcase
    end
    return {s, e};
  endfunction

  function automatic logic [1:0] thresh_map(input logic [1:0] lvl);
    logic [1:0] c;
    c = 2'h0;
    unique case (lvl)
      LVL_0: c = 2'h2;
      LVL_R: c = 2'h1;
      LVL_F: c = 2'h0;
      LVL_1: c = 2'h3;
    endcase
    return c;
  endfunction

  // ****************************************************************
  // strap synchronisation and debounce
  // ****************************************************************
  logic [NUM_STRAPS*CMP_W-1:0] strap_raw;
  logic [NUM_STRAPS*CMP_W-1:0] strap_cmp;
  logic [4:0] fast_raw;
  logic [4:0] fast_q;

  assign strap_raw = {OPMODE_STRAP, SWING_SELECT_STRAP, EMPH_STRAP_B, EMPH_STRAP_A,
    SIDE_B_BOOST_LO, SIDE_B_BOOST_HI, SIDE_A_BOOST_LO, SIDE_A_BOOST_HI,
    DETECT_LEVEL_STRAP, CONFIG_SOURCE_STRAP};
  assign fast_raw = {SD_BELOW_DEASSERT, SD_ABOVE_ASSERT, TRANSMIT_OFF_PIN};

  rcs_sync #(
    .WIDTH(NUM_STRAPS * CMP_W),
    .DEB_CYCLES(DEB_CYCLES)
  ) u_strap_sync (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .d_in(strap_raw),
    .q_out(strap_cmp)
  );

  rcs_sync #(
    .WIDTH(5),
    .DEB_CYCLES(1)
  ) u_fast_sync (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .d_in(fast_raw),
    .q_out(fast_q)
  );

  logic [1:0] lv_src;
  logic [1:0] lv_thr;
  logic [1:0] lv_ahi;
  logic [1:0] lv_alo;
  logic [1:0] lv_bhi;
  logic [1:0] lv_blo;
  logic [1:0] lv_ema;
  logic [1:0] lv_emb;
  logic [1:0] lv_sw;
  logic [1:0] lv_op;

  assign lv_src = resolve(strap_cmp[2:0]);
  assign lv_thr = resolve(strap_cmp[5:3]);
  assign lv_ahi = resolve(strap_cmp[8:6]);
  assign lv_alo = resolve(strap_cmp[11:9]);
  assign lv_bhi = resolve(strap_cmp[14:12]);
  assign lv_blo = resolve(strap_cmp[17:15]);
  assign lv_ema = resolve(strap_cmp[20:18]);
  assign lv_emb = resolve(strap_cmp[23:21]);
  assign lv_sw = resolve(strap_cmp[26:24]);
  assign lv_op = resolve(strap_cmp[29:27]);

  // ****************************************************************
  // configuration source state machine
  // ****************************************************************
  rcs_state_t state;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      state <= ST_PIN;
    else if (lv_src == LVL_0)
      state <= ST_PIN;
    else
    begin
      unique case (state)
        ST_PIN: state <= (lv_src == LVL_1) ? ST_SLAVE : ST_LOAD;
        ST_LOAD:
        begin
          if (LD_FAIL)
            state <= ST_STALL;
          else if (LD_OK)
            state <= ST_SLAVE;
        end
        ST_SLAVE: state <= ST_SLAVE;
        ST_STALL: state <= ST_STALL;
      endcase
    end
  end

  assign LOAD_REQ = (state == ST_LOAD);
  assign SLAVE_EN = (state == ST_SLAVE);
  assign CFG_STATE = state;

  // ****************************************************************
  // slave address from the setting straps
  // ****************************************************************
  logic [3:0] ad;
  assign ad = {lv_ahi[1], lv_alo[1], lv_bhi[1], lv_blo[1]};
  assign SLAVE_ADDR = ADDR_BYTE_BASE[7:1] + {3'h0, ad};
  assign LOAD_SECTION = SLAVE_ADDR;

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  logic wr_pend;
  logic rd_pend;
  logic [7:0] ph_idx;
  logic addr_ok;
  logic [7:0] reg_boost_a;
  logic [7:0] reg_boost_b;
  logic [7:0] reg_emsw_a;
  logic [7:0] reg_emsw_b;
  logic [7:0] reg_ovr;
  logic [7:0] reg_en;
  logic [7:0] reg_thr;
  logic [7:0] rd_val;
  logic [1:0] sd_on;

  assign addr_ok = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = !rd_pend;
  assign HRESP = 1'b0;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_idx <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && HWRITE;
      rd_pend <= addr_ok && !HWRITE;
      if (addr_ok)
        ph_idx <= {2'h0, HADDR[7:2]};
    end
  end

  always_comb
  begin
    rd_val = 8'h00;
    unique case (ph_idx)
      IDX_STATUS: rd_val = {SLAVE_ADDR[3:0], sd_on, state};
      IDX_BOOST_A: rd_val = reg_boost_a;
      IDX_BOOST_B: rd_val = reg_boost_b;
      IDX_EMSW_A: rd_val = reg_emsw_a;
      IDX_EMSW_B: rd_val = reg_emsw_b;
      IDX_OVERRIDE: rd_val = reg_ovr;
      IDX_REG_EN: rd_val = reg_en;
      IDX_THRESH: rd_val = reg_thr;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      HRDATA <= 32'h0000_0000;
    else if (rd_pend)
      HRDATA <= {24'h00_0000, rd_val};
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  logic sw_wr;
  logic ld_wr;
  logic [7:0] w_idx;
  logic [7:0] w_dat;

  assign ld_wr = LD_WR && (state == ST_LOAD);
  assign sw_wr = wr_pend && (reg_en[REG_EN_BIT] || ph_idx == IDX_REG_EN);
  assign w_idx = ld_wr ? LD_IDX : ph_idx;
  assign w_dat = ld_wr ? LD_DATA : HWDATA[7:0];

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      reg_boost_a <= RST_BOOST;
      reg_boost_b <= RST_BOOST;
      reg_emsw_a <= RST_EMSW;
      reg_emsw_b <= RST_EMSW;
      reg_en <= RST_REG_EN;
      reg_thr <= RST_THRESH;
    end
    else if (ld_wr || sw_wr)
    begin
      unique case (w_idx)
        IDX_BOOST_A: reg_boost_a <= w_dat;
        IDX_BOOST_B: reg_boost_b <= w_dat;
        IDX_EMSW_A: reg_emsw_a <= w_dat;
        IDX_EMSW_B: reg_emsw_b <= w_dat;
        IDX_REG_EN: reg_en <= w_dat;
        IDX_THRESH: reg_thr <= w_dat;
        default: reg_en <= reg_en;
      endcase
    end
  end

  // override flags drop when the strap returns to pin control
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      reg_ovr <= RST_OVERRIDE;
    else if (state == ST_PIN)
      reg_ovr <= RST_OVERRIDE;
    else if ((ld_wr || sw_wr) && w_idx == IDX_OVERRIDE)
      reg_ovr <= w_dat;
  end

  // ****************************************************************
  // setting selection
  // ****************************************************************
  logic use_regs;
  logic [5:0] pin_emsw_a;
  logic [5:0] pin_emsw_b;

  assign use_regs = (state != ST_PIN);
  assign pin_emsw_a = emsw_map(lv_sw, lv_ema);
  assign pin_emsw_b = emsw_map(lv_sw, lv_emb);

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      BOOST_A <= RST_BOOST;
      BOOST_B <= RST_BOOST;
      EMPH_A <= RST_EMSW[EMSW_EMPH_LSB +: 3];
      EMPH_B <= RST_EMSW[EMSW_EMPH_LSB +: 3];
      SWING_A <= RST_EMSW[EMSW_SWING_LSB +: 3];
      SWING_B <= RST_EMSW[EMSW_SWING_LSB +: 3];
    end
    else if (use_regs)
    begin
      BOOST_A <= reg_boost_a;
      BOOST_B <= reg_boost_b;
      EMPH_A <= reg_emsw_a[EMSW_EMPH_LSB +: 3];
      EMPH_B <= reg_emsw_b[EMSW_EMPH_LSB +: 3];
      SWING_A <= reg_emsw_a[EMSW_SWING_LSB +: 3];
      SWING_B <= reg_emsw_b[EMSW_SWING_LSB +: 3];
    end
    else
    begin
      BOOST_A <= boost_map(lv_ahi, lv_alo);
      BOOST_B <= boost_map(lv_bhi, lv_blo);
      EMPH_A <= pin_emsw_a[2:0];
      EMPH_B <= pin_emsw_b[2:0];
      SWING_A <= pin_emsw_a[5:3];
      SWING_B <= pin_emsw_b[5:3];
    end
  end

  // pin-ruled controls, each with its own override
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      THRESH_A <= RST_THRESH[THR_A_LSB +: 2];
      THRESH_B <= RST_THRESH[THR_B_LSB +: 2];
      OPMODE <= LVL_0;
      TX_OFF <= 1'b0;
    end
    else
    begin
      if (use_regs && reg_ovr[OVR_THR_EN])
      begin
        THRESH_A <= reg_thr[THR_A_LSB +: 2];
        THRESH_B <= reg_thr[THR_B_LSB +: 2];
      end
      else
      begin
        THRESH_A <= thresh_map(lv_thr);
        THRESH_B <= thresh_map(lv_thr);
      end
      if (use_regs && reg_ovr[OVR_OPMODE_EN])
        OPMODE <= reg_ovr[OVR_OPMODE_LSB +: 2];
      else
        OPMODE <= lv_op;
      if (use_regs && reg_ovr[OVR_TXOFF_EN])
        TX_OFF <= reg_ovr[OVR_TXOFF_VAL];
      else
        TX_OFF <= fast_q[0];
    end
  end

  // ****************************************************************
  // signal detect hysteresis and output gating
  // ****************************************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      sd_on <= 2'h0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (fast_q[3 + i])
          sd_on[i] <= 1'b0;
        else if (fast_q[1 + i])
          sd_on[i] <= 1'b1;
      end
    end
  end

  // transmit off only gates outputs, registers are untouched
  assign OUT_EN = sd_on & {2{!TX_OFF}};

endmodule

// >>> sim/rcs_top_properties.sv
// concurrent checks on the configuration selector ports
`timescale 1ns/1ps
module rcs_checker (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // register bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  // pins and load link
  input wire logic TRANSMIT_OFF_PIN,
  input wire logic [1:0] SD_ABOVE_ASSERT,
  input wire logic [1:0] SD_BELOW_DEASSERT,
  input wire logic LD_OK,
  input wire logic LD_FAIL,
  // settings and state
  input wire logic LOAD_REQ,
  input wire logic [6:0] LOAD_SECTION,
  input wire logic SLAVE_EN,
  input wire logic [7:0] BOOST_A,
  input wire logic TX_OFF,
  input wire logic [1:0] OUT_EN,
  input wire logic [6:0] SLAVE_ADDR,
  input wire logic [1:0] CFG_STATE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ****
  // bus read handshake
  // ****
  sequence rd_taken;
    HSEL && HREADY && HTRANS[1] && !HWRITE;
  endsequence
  sequence rd_answer;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  read_wait_a: assert property (rd_taken |=> rd_answer)
    else $error("read data phase length wrong");
  // ****
  // configuration rules
  // ****
  out_gate_a: assert property (TX_OFF |-> OUT_EN == 2'b00)
    else $error("output enabled while transmit off");
  detect_on_a: assert property (
    (SD_ABOVE_ASSERT[0] && !SD_BELOW_DEASSERT[0]) [*6] |-> (TX_OFF || OUT_EN[0]))
    else $error("output not enabled above assert level");
  detect_off_a: assert property (SD_BELOW_DEASSERT[0] [*6] |-> !OUT_EN[0])
    else $error("output not disabled below deassert level");
  tx_pin_a: assert property ((CFG_STATE == 2'b00 && TRANSMIT_OFF_PIN) [*6] |-> TX_OFF)
    else $error("transmit off pin ignored in pin mode");
  state_map_a: assert property (
    LOAD_REQ == (CFG_STATE == 2'b01) && SLAVE_EN == (CFG_STATE == 2'b10))
    else $error("load request or slave enable disagrees with state");
  section_a: assert property (LOAD_REQ |-> LOAD_SECTION == SLAVE_ADDR)
    else $error("load section is not own address");
  load_ok_a: assert property (
    LOAD_REQ && LD_OK && !LD_FAIL |=> SLAVE_EN && CFG_STATE == 2'b10)
    else $error("successful load did not enter slave");
  load_fail_a: assert property (LOAD_REQ && LD_FAIL |=> !SLAVE_EN && CFG_STATE == 2'b11)
    else $error("failed load did not stall");
  stall_hold_a: assert property (
    CFG_STATE == 2'b11 |=> CFG_STATE == 2'b11 || CFG_STATE == 2'b00)
    else $error("stall left other than to pin mode");
  tx_keep_a: assert property (
    $rose(TX_OFF) && CFG_STATE == $past(CFG_STATE, 2) |-> $stable(BOOST_A))
    else $error("transmit off changed a setting");
endmodule

bind rcs_top rcs_checker chk_u (.REF_CLK, .SYS_RST, .HSEL, .HTRANS, .HWRITE, .HREADY,
  .HREADYOUT, .TRANSMIT_OFF_PIN, .SD_ABOVE_ASSERT, .SD_BELOW_DEASSERT, .LD_OK, .LD_FAIL,
  .LOAD_REQ, .LOAD_SECTION, .SLAVE_EN, .BOOST_A, .TX_OFF, .OUT_EN, .SLAVE_ADDR, .CFG_STATE);

// >>> sim/rcs_load_model.sv
// eeprom load engine model on the load link
`timescale 1ns/1ps
module rcs_load_model (
  // clock
  input wire logic clk,
  // behaviour chosen by the bench
  input wire logic fail_mode,
  input wire logic slow,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  // load link
  input wire logic load_req,
  output logic ld_wr,
  output logic [7:0] ld_idx,
  output logic [7:0] ld_data,
  output logic ld_ok,
  output logic ld_fail
);
  initial
  begin
    ld_wr = 1'b0;
    ld_ok = 1'b0;
    ld_fail = 1'b0;
    ld_idx = 8'h00;
    ld_data = 8'h00;
    forever
    begin
      @(posedge clk);
      if (load_req)
      begin
        repeat (slow ? 6 : 0) @(posedge clk);
        ld_wr <= 1'b1;
        ld_idx <= wr_idx;
        ld_data <= wr_data;
        @(posedge clk);
        ld_wr <= 1'b0;
        ld_idx <= ~wr_idx;
        ld_data <= ~wr_data;
        ld_ok <= !fail_mode;
        ld_fail <= fail_mode;
        @(posedge clk);
        ld_ok <= 1'b0;
        ld_fail <= 1'b0;
        while (load_req)
          @(posedge clk);
      end
    end
  end
endmodule

// >>> sim/rcs_top_bench.sv
// self-checking bench for the configuration selector
`timescale 1ns/1ps
module rcs_top_bench;
  import rcs_pkg::*;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, tx_pin = 0, ld_fm = 0, ld_slow = 0;
  logic [1:0] htrans = 0, sd_up = 0, sd_dn = 0, l_ahi, l_alo, l_bhi, l_blo, l_thr;
  logic [7:0] haddr = 0, ld_i = 0, ld_d = 0, rd, rv;
  logic [31:0] hwdata = 0;
  logic [2:0] s_cfg = 0, s_thr = 0, s_ahi = 0, s_alo = 0, s_bhi = 0, s_blo = 0;
  logic [2:0] s_ema = 0, s_emb = 0, s_sw = 0, s_op = 0;
  wire logic hready, ld_wr, ld_ok, ld_fail, load_req, slave_en, tx_off;
  wire logic [31:0] hrdata;
  wire logic [7:0] ld_idx, ld_data, boost_a, boost_b;
  wire logic [2:0] emph_a, swing_a, emph_b;
  wire logic [1:0] thr_a, thr_b, out_en, cfg_state, opmode;
  wire logic [6:0] slave_addr;
  int errors = 0, samples_checked = 0;
  // ****
  // expectations by level code 0, R, F, 1
  // ****
  logic [2:0] lv[4] = '{3'b000, 3'b001, 3'b011, 3'b111};
  logic [2:0] emph_tab[4] = '{3'b000, 3'b011, 3'b010, 3'b101};
  logic [2:0] swing_tab[4] = '{3'b000, 3'b101, 3'b011, 3'b000};
  logic [1:0] thr_tab[4] = '{2'b10, 2'b01, 2'b00, 2'b11};
  logic [7:0] boost_tab[16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0b, 8'h0f,
    8'h55, 8'h1f, 8'h2f, 8'h3f, 8'haa, 8'h7f, 8'hbf, 8'hff};
  function automatic logic [6:0] addr_exp();
    return ADDR_BYTE_BASE[7:1] + 7'({l_ahi[1], l_alo[1], l_bhi[1], l_blo[1]});
  endfunction
  rcs_top dut_u (.REF_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(), .CONFIG_SOURCE_STRAP(s_cfg), .DETECT_LEVEL_STRAP(s_thr),
    .SIDE_A_BOOST_HI(s_ahi), .SIDE_A_BOOST_LO(s_alo), .SIDE_B_BOOST_HI(s_bhi),
    .SIDE_B_BOOST_LO(s_blo), .EMPH_STRAP_A(s_ema), .EMPH_STRAP_B(s_emb),
    .SWING_SELECT_STRAP(s_sw), .OPMODE_STRAP(s_op), .TRANSMIT_OFF_PIN(tx_pin),
    .SD_ABOVE_ASSERT(sd_up), .SD_BELOW_DEASSERT(sd_dn), .LD_WR(ld_wr), .LD_IDX(ld_idx),
    .LD_DATA(ld_data), .LD_OK(ld_ok), .LD_FAIL(ld_fail), .LOAD_REQ(load_req),
    .LOAD_SECTION(), .SLAVE_EN(slave_en), .BOOST_A(boost_a), .BOOST_B(boost_b),
    .EMPH_A(emph_a), .EMPH_B(emph_b), .SWING_A(swing_a), .SWING_B(), .THRESH_A(thr_a),
    .THRESH_B(thr_b), .OPMODE(opmode), .TX_OFF(tx_off), .OUT_EN(out_en), .SLAVE_ADDR(slave_addr),
    .CFG_STATE(cfg_state));
  rcs_load_model eeprom_u (.clk(clk), .fail_mode(ld_fm), .slow(ld_slow), .wr_idx(ld_i),
    .wr_data(ld_d), .load_req(load_req), .ld_wr(ld_wr), .ld_idx(ld_idx),
    .ld_data(ld_data), .ld_ok(ld_ok), .ld_fail(ld_fail));
  // ****
  // tasks
  // ****
  task automatic report_and_stop();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {idx[5:0], 2'b00};
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    rd = hrdata[7:0];
    hsel <= 1'b0;
  endtask
  task automatic pins(input logic [1:0] hi, input logic [1:0] lo);
    l_ahi = hi;
    l_alo = lo;
    l_bhi = 2'($urandom);
    l_blo = 2'($urandom);
    l_thr = 2'($urandom);
    s_ahi <= lv[hi];
    s_alo <= lv[lo];
    s_bhi <= lv[l_bhi];
    s_blo <= lv[l_blo];
    s_thr <= lv[l_thr];
    s_ema <= lv[lo];
    s_sw <= lv[hi];
    s_emb <= lv[l_blo];
    s_op <= lv[l_thr];
    wait_clk(64);
  endtask
  initial
    forever #10 clk = ~clk;
  initial
  begin
    wait_clk(20000);
    errors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(92));
    wait_clk(4);
    rst <= 1'b0;
    wait_clk(1);
    chk("swing_rst", RST_EMSW[5:3], swing_a);
    for (int i = 0; i < 16; i++)
    begin
      pins(2'(i >> 2), 2'(i));
      chk("boost_a", boost_tab[i], boost_a);
      chk("boost_b", boost_tab[{l_bhi, l_blo}], boost_b);
      chk("slave_addr", addr_exp(), slave_addr);
      chk("thresh_a", thr_tab[l_thr], thr_a);
      chk("thresh_b", thr_tab[l_thr], thr_b);
      chk("opmode", l_thr, opmode);
      if (i < 12)
      begin
        chk("emph_a", emph_tab[i % 4], emph_a);
        chk("emph_b", emph_tab[l_blo], emph_b);
        chk("swing_a", swing_tab[i / 4], swing_a);
      end
    end
    s_cfg <= lv[LVL_1];
    s_thr <= lv[LVL_1];
    wait_clk(64);
    chk("state", 2'b10, cfg_state);
    chk("boost_reg", RST_BOOST, boost_a);
    ahb(1'b1, IDX_BOOST_A, 8'h5a);
    ahb(1'b0, IDX_BOOST_A, 8'h00);
    chk("boost_locked", RST_BOOST, rd);
    rv = 8'($urandom);
    ahb(1'b1, IDX_REG_EN, 8'h08);
    ahb(1'b1, IDX_BOOST_A, rv);
    ahb(1'b1, IDX_EMSW_A, 8'h21);
    ahb(1'b1, IDX_THRESH, 8'h06);
    ahb(1'b0, IDX_BOOST_A, 8'h00);
    chk("boost_rd", rv, rd);
    chk("boost_out", rv, boost_a);
    chk("emph_reg", 3'b001, emph_a);
    chk("swing_reg", 3'b100, swing_a);
    chk("thr_pin", thr_tab[LVL_1], thr_a);
    ahb(1'b0, IDX_STATUS, 8'h00);
    chk("status", {4'(addr_exp()), 4'b0010}, rd);
    ahb(1'b0, 8'h3f, 8'h00);
    chk("unmapped", 8'h00, rd);
    ahb(1'b1, IDX_OVERRIDE, 8'h20);
    s_thr <= lv[LVL_0];
    wait_clk(64);
    chk("thr_ovr_a", 2'b01, thr_a);
    chk("thr_ovr_b", 2'b10, thr_b);
    sd_up <= 2'b11;
    wait_clk(8);
    chk("out_en_on", 2'b11, out_en);
    sd_up <= 2'b00;
    sd_dn <= 2'b01;
    wait_clk(8);
    sd_dn <= 2'b00;
    wait_clk(8);
    chk("out_en_hold", 2'b10, out_en);
    tx_pin <= 1'b1;
    wait_clk(8);
    chk("tx_out_en", 2'b00, out_en);
    ahb(1'b0, IDX_BOOST_A, 8'h00);
    chk("tx_keeps_reg", rv, rd);
    ahb(1'b1, IDX_OVERRIDE, 8'h21);
    wait_clk(2);
    chk("tx_ovr", 2'b10, out_en);
    s_cfg <= lv[LVL_0];
    wait_clk(64);
    chk("tx_pin_back", 1'b1, tx_off);
    chk("boost_pin_back", boost_tab[{l_ahi, l_alo}], boost_a);
    ahb(1'b0, IDX_OVERRIDE, 8'h00);
    chk("ovr_clear", 8'h00, rd);
    tx_pin <= 1'b0;
    ld_i <= IDX_BOOST_B;
    ld_d <= 8'($urandom);
    ld_slow <= 1'b1;
    s_cfg <= lv[LVL_F];
    for (int t = 0; t < 200 && slave_en !== 1'b1; t++)
      @(posedge clk);
    wait_clk(2);
    chk("load_state", 2'b10, cfg_state);
    chk("load_boost", ld_d, boost_b);
    s_cfg <= lv[LVL_0];
    wait_clk(64);
    ld_fm <= 1'b1;
    ld_slow <= 1'b0;
    s_cfg <= lv[LVL_F];
    wait_clk(80);
    chk("stall", 2'b11, cfg_state);
    chk("stall_silent", 1'b0, slave_en);
    report_and_stop();
  end
endmodule
